// file: rtl/dcbs_consts.vh
// Purpose: constants for the d channel double buffer status block
// Assumes: 32-bit classic wishbone register access, byte addresses
// Notes: definitions only
`ifndef DCBS_CONSTS_VH
`define DCBS_CONSTS_VH
// register byte offsets
`define DCBS_STATUS_OFS 4'h0
`define DCBS_MODE_OFS 4'h4
`define DCBS_RXWIN_OFS 4'h8
`define DCBS_TXWIN_OFS 4'hC
// status bit positions
`define DCBS_BIT_RX_READY 0
`define DCBS_BIT_RX_ERR 1
`define DCBS_BIT_TX_EMPTY 2
`define DCBS_BIT_RX_FULL 3
`define DCBS_BIT_TX_LOW 4
`define DCBS_BIT_TX_UF 5
// mode bit that selects double buffering
`define DCBS_MODE_DOUBLE 6
// geometry
`define DCBS_WORD_BYTES 6
`define DCBS_HALVES 2
`define DCBS_MODE_RESET 8'h40
// status after reset: tx low and tx empty set
`define DCBS_STATUS_RESET 8'h14
// byte sent when the transmit ring is dry
`define DCBS_IDLE_FILL 8'h7e
`endif

// file: rtl/dcbs_half.v
// Purpose: one half of a two-half code word buffer, byte count and check flag
// Assumes: writer and reader never address the same half in one cycle
// Notes: counts bytes 0..6; full when all six are present
module dcbs_half #(
    parameter WORD_BYTES = 6
) (
    input wire clk_i,
    input wire rst_i,
    input wire wr_i,
    input wire err_i,
    input wire rd_i,
    output wire full_o,
    output reg err_o,
    output reg [2:0] cnt_o
);
    assign full_o = (cnt_o == WORD_BYTES[2:0]);
    // byte count; a read clears the whole word, a write adds one
    always @(posedge clk_i) begin
        if (rst_i) begin
            cnt_o <= 3'h0;
            err_o <= 1'b0;
        end else if (rd_i && cnt_o != 3'h0) begin
            // rd only comes with the last byte read, so the whole word goes at once
            cnt_o <= 3'h0;
            err_o <= 1'b0;
        end else if (wr_i && !full_o) begin
            cnt_o <= cnt_o + 3'h1;
            // error is sticky over the word, reported once it is complete
            if (cnt_o == 3'h0)
                err_o <= err_i;
            else
                err_o <= err_o | err_i;
        end
    end
endmodule

// file: rtl/dcbs_top.v
// Purpose: status flags of the d channel two code word double buffer
// Assumes: link side delivers received bytes and takes transmit bytes
// Notes: register slave on classic wishbone, one-cycle ack
//
// Chosen here: the Wishbone slave port and the placing of the registers.
`include "dcbs_consts.vh"
module dcbs_top #(
    parameter WORD_BYTES = `DCBS_WORD_BYTES
) (
    input wire clk_i,
    input wire rst_i,
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [3:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    output reg [31:0] dat_o,
    output reg ack_o,
    input wire rx_byte_valid_i,
    input wire [7:0] rx_byte_i,
    input wire rx_byte_err_i,
    input wire tx_byte_req_i,
    output reg [7:0] tx_byte_o,
    output reg tx_idle_fill_o,
    output reg tx_empty_irq_o
);
    localparam TOTAL = WORD_BYTES * `DCBS_HALVES;

    // receive storage: two halves of one code word each
    reg [7:0] rx_mem [0:TOTAL-1];
    reg [7:0] tx_mem [0:TOTAL-1];
    reg rx_wsel;
    reg rx_rsel;
    reg [2:0] rx_rptr;
    reg [3:0] tx_wptr;
    reg [3:0] tx_rptr;
    reg [3:0] tx_cnt;
    reg [7:0] mode;
    reg [7:0] status;
    reg tx_uf;
    wire [2:0] cnt0;
    wire [2:0] cnt1;
    wire full0;
    wire full1;
    wire err0;
    wire err1;

    wire req = cyc_i & stb_i & ~ack_o;
    wire rd_status = req & ~we_i & (adr_i == `DCBS_STATUS_OFS);
    wire rd_rx = req & ~we_i & (adr_i == `DCBS_RXWIN_OFS);
    wire wr_tx = req & we_i & sel_i[0] & (adr_i == `DCBS_TXWIN_OFS);
    wire wr_mode = req & we_i & sel_i[0] & (adr_i == `DCBS_MODE_OFS);
    wire dbl = mode[`DCBS_MODE_DOUBLE];

    wire vis_full = rx_rsel ? full1 : full0;
    wire rd_pop = rd_rx & vis_full;
    wire rd_last = rd_pop & (rx_rptr == WORD_BYTES[2:0] - 3'h1);
    wire tx_push = wr_tx & (tx_cnt != TOTAL[3:0]);
    wire tx_pop = tx_byte_req_i & (tx_cnt != 4'h0);
    wire wsel_full = rx_wsel ? full1 : full0;
    wire rx_push = rx_byte_valid_i & ~wsel_full;

    // each half counts its own six bytes
    dcbs_half #(.WORD_BYTES(WORD_BYTES)) u_half0 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wr_i(rx_push & ~rx_wsel),
        .err_i(rx_byte_err_i),
        .rd_i(rd_last & ~rx_rsel),
        .full_o(full0),
        .err_o(err0),
        .cnt_o(cnt0)
    );
    dcbs_half #(.WORD_BYTES(WORD_BYTES)) u_half1 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wr_i(rx_push & rx_wsel),
        .err_i(rx_byte_err_i),
        .rd_i(rd_last & rx_rsel),
        .full_o(full1),
        .err_o(err1),
        .cnt_o(cnt1)
    );

    // half drain: the counter is cleared at the last byte, so drop
    // the whole word at once by feeding rd only then
    // receive write side: fill one half, then move to the other
    always @(posedge clk_i) begin
        if (rst_i) begin
            rx_wsel <= 1'b0;
        end else if (rx_push) begin
            rx_mem[{rx_wsel, 3'h0} == 4'h0 ? {1'b0, cnt0} : 4'h6 + {1'b0, cnt1}] <= rx_byte_i;
            if ((rx_wsel ? cnt1 : cnt0) == WORD_BYTES[2:0] - 3'h1)
                rx_wsel <= ~rx_wsel;
        end
    end

    // software read side: last byte of a half hands access over
    always @(posedge clk_i) begin
        if (rst_i) begin
            rx_rsel <= 1'b0;
            rx_rptr <= 3'h0;
        end else if (rd_pop) begin
            if (rd_last) begin
                rx_rptr <= 3'h0;
                rx_rsel <= ~rx_rsel;
            end else begin
                rx_rptr <= rx_rptr + 3'h1;
            end
        end
    end

    // transmit ring of two code words
    always @(posedge clk_i) begin
        if (rst_i) begin
            tx_wptr <= 4'h0;
            tx_rptr <= 4'h0;
            tx_cnt <= 4'h0;
            tx_byte_o <= 8'h00;
            tx_idle_fill_o <= 1'b0;
        end else begin
            if (tx_push) begin
                tx_mem[tx_wptr] <= dat_i[7:0];
                tx_wptr <= (tx_wptr == TOTAL[3:0] - 4'h1) ? 4'h0 : tx_wptr + 4'h1;
            end
            if (tx_pop) begin
                tx_byte_o <= tx_mem[tx_rptr];
                tx_rptr <= (tx_rptr == TOTAL[3:0] - 4'h1) ? 4'h0 : tx_rptr + 4'h1;
            end else if (tx_byte_req_i) begin
                tx_byte_o <= `DCBS_IDLE_FILL; // idle fill pattern
            end
            tx_idle_fill_o <= tx_byte_req_i & ~tx_pop;
            tx_cnt <= tx_cnt + {3'h0, tx_push} - {3'h0, tx_pop};
        end
    end

    // underflow: set wins over the read clear
    always @(posedge clk_i) begin
        if (rst_i)
            tx_uf <= 1'b0;
        else if (tx_byte_req_i & ~tx_pop & dbl)
            tx_uf <= 1'b1;
        else if (rd_status)
            tx_uf <= 1'b0;
    end

    // status image refreshed every cycle from the counts in double mode, cleared to zero otherwise
    always @(posedge clk_i) begin
        if (rst_i) begin
            status <= `DCBS_STATUS_RESET;
            tx_empty_irq_o <= 1'b1;
        end else if (dbl) begin
            status[7] <= 1'b0;
            status[6] <= 1'b0;
            status[`DCBS_BIT_TX_UF] <= tx_uf | (tx_byte_req_i & ~tx_pop);
            status[`DCBS_BIT_TX_LOW] <= (tx_cnt < 2 * WORD_BYTES);
            status[`DCBS_BIT_RX_FULL] <= full0 & full1 & ~rd_last;
            status[`DCBS_BIT_TX_EMPTY] <= (tx_cnt < WORD_BYTES);
            status[`DCBS_BIT_RX_ERR] <= vis_full & (rx_rsel ? err1 : err0);
            status[`DCBS_BIT_RX_READY] <= full0 | full1;
            tx_empty_irq_o <= (tx_cnt < 2 * WORD_BYTES); // until filled
        end else begin
            status <= 8'h00;
            tx_empty_irq_o <= 1'b0;
        end
    end

    // wishbone slave: ack one cycle after request, dropped next cycle
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
            mode <= `DCBS_MODE_RESET;
        end else begin
            ack_o <= req;
            if (wr_mode)
                mode <= dat_i[7:0];
            if (req & ~we_i) begin
                case (adr_i)
                    `DCBS_STATUS_OFS: dat_o <= {24'h00_0000, status};
                    `DCBS_MODE_OFS: dat_o <= {24'h00_0000, mode};
                    `DCBS_RXWIN_OFS:
                        dat_o <= {24'h00_0000, vis_full ?
                            rx_mem[rx_rsel ? 4'h6 + {1'b0, rx_rptr} : {1'b0, rx_rptr}] : 8'h00};
                    default: dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule

// file: verification/dcbs_monitor.sv
// Purpose: port checks for the buffer status block
// Assumes: one clock, synchronous active high reset
// Notes: bound to dcbs_top after the module
module dcbs_monitor (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic [7:0] tx_byte_o,
    input wire logic tx_idle_fill_o,
    input wire logic tx_empty_irq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic st;
    // status answer present this cycle
    assign st = ack_o && !we_i && adr_i == 4'h0;
    // bus timing and status field relations
    property p_ack; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
    a_ack: assert property (p_ack) else $error("late ack");
    property p_pulse; ack_o |=> !ack_o; endproperty
    a_pulse: assert property (p_pulse) else $error("ack held");
    property p_rst; $fell(rst_i) |-> !ack_o && dat_o == 32'h0000_0000 && tx_empty_irq_o; endproperty
    a_rst: assert property (p_rst) else $error("bad reset state");
    property p_top; st |-> dat_o[31:7] == 25'h000_0000; endproperty
    a_top: assert property (p_top) else $error("reserved bits set");
    property p_full; st && dat_o[3] |-> dat_o[0]; endproperty
    a_full: assert property (p_full) else $error("full without ready");
    property p_err; st && dat_o[1] |-> dat_o[0]; endproperty
    a_err: assert property (p_err) else $error("error without word");
    property p_low; st && dat_o[2] |-> dat_o[4]; endproperty
    a_low: assert property (p_low) else $error("empty without low");
    property p_fill; tx_idle_fill_o |-> tx_byte_o == 8'h7e; endproperty
    a_fill: assert property (p_fill) else $error("fill not idle");
endmodule
bind dcbs_top dcbs_monitor mon_u (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .dat_o,
    .ack_o, .tx_byte_o, .tx_idle_fill_o, .tx_empty_irq_o);

// file: verification/dcbs_link.sv
// Purpose: link model delivering received code words
// Assumes: one byte every GAP plus one cycles
// Notes: idle data toggles so stale bytes never look valid
module dcbs_link #(
    parameter int GAP = 2
) (
    input wire logic clk_i,
    input wire logic send_i,
    input wire logic err_i,
    output logic rx_byte_valid_o = 1'b0,
    output logic [7:0] rx_byte_o = 8'h00,
    output logic rx_byte_err_o = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    int left = 0;
    int pause = 0;
    // six paced bytes per word
    always @(posedge clk_i) begin
        rx_byte_valid_o <= 1'b0;
        rx_byte_err_o <= 1'b0;
        rx_byte_o <= ~rx_byte_o;
        if (send_i) begin
            left <= 6;
            pause <= GAP;
        end else if (pause > 0) begin
            pause <= pause - 1;
        end else if (left > 0) begin
            rx_byte_valid_o <= 1'b1;
            rx_byte_o <= 8'h50 + 8'(left);
            rx_byte_err_o <= err_i;
            left <= left - 1;
            pause <= GAP;
        end
    end
endmodule

// file: verification/test_d_channel_double_buffer_status.sv
// Purpose: self-checking bench for the buffer status block
// Assumes: one-cycle ack, status refreshed a cycle after counts
// Notes: received words come from dcbs_link
module test_d_channel_double_buffer_status;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, tx_byte_req_i = 0;
    logic send = 0, bad = 0, ack_o, rx_byte_valid_i, rx_byte_err_i, tx_idle_fill_o, irq;
    logic [3:0] adr_i = 4'h0;
    logic [31:0] dat_i = 32'h0000_0000, dat_o, q;
    logic [7:0] rx_byte_i, tx_byte_o;
    int err_total = 0, tests_run = 0;
    dcbs_top dut_u (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i(4'hF), .dat_i, .dat_o,
        .ack_o, .rx_byte_valid_i, .rx_byte_i, .rx_byte_err_i, .tx_byte_req_i, .tx_byte_o,
        .tx_idle_fill_o, .tx_empty_irq_o(irq));
    dcbs_link link_u (.clk_i, .send_i(send), .err_i(bad), .rx_byte_valid_o(rx_byte_valid_i),
        .rx_byte_o(rx_byte_i), .rx_byte_err_o(rx_byte_err_i));
    // 125 mhz clock
    initial begin
        forever #4 clk_i = ~clk_i;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // one classic cycle; only the watchdog ends a stuck wait
    task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        wb(a, 1'b0, 32'h0000_0000);
        chk(q, e);
    endtask
    task automatic rx_word(input logic e);
        send <= 1'b1;
        bad <= e;
        @(posedge clk_i);
        send <= 1'b0;
        repeat (30) @(posedge clk_i);
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // hang guard, far beyond the run
    initial begin
        repeat (5000) @(posedge clk_i);
        err_total++;
        print_verdict();
    end
    // main sequence
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        // the bench leaves the empty indication unserviced until loaded
        chk({31'h0, irq}, 32'h0000_0001);
        rd(4'h0, 32'h0000_0014);
        rd(4'h4, 32'h0000_0040);
        rd(4'h2, 32'h0000_0000);
        for (int i = 0; i < 12; i++) begin
            wb(4'hC, 1'b1, 32'h0000_0030 + i);
            if (i == 5) rd(4'h0, 32'h0000_0010);
        end
        rd(4'h0, 32'h0000_0000);
        chk({31'h0, irq}, 32'h0000_0000);
        $display("test reset and transmit load done");
        rx_word(1'b1);
        rd(4'h0, 32'h0000_0003);
        rx_word(1'b0);
        rd(4'h0, 32'h0000_000B);
        for (int i = 0; i < 12; i++) begin
            wb(4'h8, 1'b0, 32'h0000_0000);
            if (i == 0) chk(q, 32'h0000_0056);
            if (i == 5) rd(4'h0, 32'h0000_0001);
        end
        rd(4'h0, 32'h0000_0000);
        $display("test receive done");
        // twelve loaded bytes come out in order, the thirteenth is idle fill
        for (int k = 0; k < 13; k++) begin
            tx_byte_req_i <= 1'b1;
            @(posedge clk_i);
            tx_byte_req_i <= 1'b0;
            @(posedge clk_i);
            chk({23'h0, tx_idle_fill_o, tx_byte_o},
                (k < 12) ? 32'h0000_0030 + k : 32'h0000_017E);
            repeat (2) @(posedge clk_i);
        end
        rd(4'h0, 32'h0000_0034);
        rd(4'h0, 32'h0000_0014);
        wb(4'h4, 1'b1, 32'h0000_0000);
        rd(4'h0, 32'h0000_0000);
        $display("test underflow and mode done");
        print_verdict();
    end
endmodule
